// *** src/fsc_div_if.sv ***
`timescale 1ns/1ns
interface fsc_div_if;
  logic [9:0]  int_div;
  logic [23:0] frac;
  logic        tick;
  logic        fb_pulse;
  logic        carry;

  modport ctrl (output int_div, output frac, output tick, input fb_pulse, input carry);
  modport div  (input int_div, input frac, input tick, output fb_pulse, output carry);
endinterface : fsc_div_if

// *** src/fsc_frac_div.sv ***
`timescale 1ns/1ns
module fsc_frac_div (
  input  wire logic clk_i,
  input  wire logic rst_i,
  fsc_div_if.div    d
);

  logic [10:0] cnt_reg;
  logic [23:0] acc_reg;
  logic        carry_reg;
  logic        pulse_reg;
  logic [24:0] acc_sum;
  logic [10:0] modulus;

  // ===========================================================
  // Sigma accumulator picks N or N+1 per output period
  assign acc_sum = {1'b0, acc_reg} + {1'b0, d.frac};
  assign modulus = {1'b0, d.int_div} + {10'h000, acc_sum[24]};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg   <= 11'h000;
      acc_reg   <= 24'h000000;
      carry_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= 1'b0;
      if (d.tick) begin
        if (cnt_reg == 11'h000) begin
          pulse_reg <= 1'b1;
          // Modulus latched per period, so mid-period writes cannot glitch it
          cnt_reg   <= modulus - 11'h001;
          acc_reg   <= acc_sum[23:0];
          carry_reg <= acc_sum[24];
        end else begin
          cnt_reg <= cnt_reg - 11'h001;
        end
      end
    end
  end

  assign d.fb_pulse = pulse_reg;
  assign d.carry    = carry_reg;

  // ===========================================================
  // Checks
  logic [10:0] gap_reg;
  logic [10:0] last_mod_reg;
  logic        primed_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap_reg      <= 11'h000;
      last_mod_reg <= 11'h000;
      primed_reg   <= 1'b0;
    end else if (d.tick) begin
      if (cnt_reg == 11'h000) begin
        gap_reg      <= 11'h000;
        last_mod_reg <= modulus;
        primed_reg   <= 1'b1;
      end else begin
        gap_reg <= gap_reg + 11'h001;
      end
    end
  end

  period_length_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (d.tick && cnt_reg == 11'h000 && primed_reg) |-> gap_reg == last_mod_reg - 11'h001)
    else $error("feedback period differs from loaded modulus");

  carry_period_c: cover property (@(posedge clk_i) disable iff (rst_i)
    d.tick && cnt_reg == 11'h000 && acc_sum[24]);

endmodule : fsc_frac_div

// *** src/fsc_pkg.sv ***
package fsc_pkg;

  // ===========================================================
  // Bus widths
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;

  // ===========================================================
  // Register word addresses
  localparam logic [6:0] ADDR_REF_DIV   = 7'h00;
  localparam logic [6:0] ADDR_CONFIG_WORD_ONE      = 7'h01;
  localparam logic [6:0] ADDR_CONFIG_WORD_TWO      = 7'h02;
  localparam logic [6:0] ADDR_CONFIG_WORD_FOUR      = 7'h03;
  localparam logic [6:0] ADDR_A_INT     = 7'h04;
  localparam logic [6:0] ADDR_A_FRAC_HI = 7'h05;
  localparam logic [6:0] ADDR_A_FRAC_LO = 7'h06;
  localparam logic [6:0] ADDR_A_PUMP    = 7'h07;
  localparam logic [6:0] ADDR_B_INT     = 7'h08;
  localparam logic [6:0] ADDR_B_FRAC_HI = 7'h09;
  localparam logic [6:0] ADDR_B_FRAC_LO = 7'h0a;
  localparam logic [6:0] ADDR_B_PUMP    = 7'h0b;
  localparam logic [6:0] ADDR_STATUS    = 7'h0c;

  // ===========================================================
  // Field positions
  localparam int REF_RATIO_LSB  = 13;
  localparam int REF_BYPASS_BIT = 12;
  localparam int CONFIG_WORD_ONE_ACT_FILT  = 0;
  localparam int CONFIG_WORD_ONE_PD_POL    = 1;
  localparam int CONFIG_WORD_ONE_DUAL_BANK = 2;
  localparam int CONFIG_WORD_ONE_FACT_LSB  = 3;
  localparam int CONFIG_WORD_ONE_KEEP_XTAL = 5;
  localparam int CONFIG_WORD_ONE_AUTO_CAL  = 6;
  localparam int CONFIG_WORD_ONE_PUMP_LOW  = 7;
  localparam int CONFIG_WORD_FOUR_FINE_BIT  = 4;
  localparam int FRAC_LO_W      = 8;
  localparam int FRAC_W         = 24;
  localparam int INT_W          = 10;
  localparam int PUMP_W         = 5;

  // ===========================================================
  // Reset values and encodings
  localparam logic [2:0]  REF_RATIO_DEF   = 3'h2;
  localparam logic [2:0]  REF_RATIO_MIN   = 3'h2;
  localparam logic [2:0]  REF_RATIO_MAX   = 3'h7;
  localparam logic [2:0]  REF_RATIO_ONE   = 3'h1;
  localparam logic        REF_BYPASS_DEF  = 1'b1;
  localparam logic [1:0]  BAND_FACT_DEF   = 2'h1;
  localparam logic [4:0]  PUMP_CODE_DEF   = 5'h1f;
  localparam logic [7:0]  PUMP_FULL_UA    = 8'h78;
  localparam logic [7:0]  PUMP_LOW_UA     = 8'h1e;
  localparam logic [3:0]  MIX_BIAS_DEF    = 4'h4;
  localparam logic [3:0]  XTAL_COARSE_DEF = 4'h4;
  localparam logic        XTAL_FINE_DEF   = 1'b0;
  localparam logic [9:0]  INT_DIV_DEF     = 10'h05c;
  localparam logic        BANK_A          = 1'b0;
  localparam logic        BANK_B          = 1'b1;
  localparam logic [10:0] BAND_SEL_PD_CYCLES = 11'h5dc;

  typedef enum logic [1:0] {
    FSC_BS_IDLE = 2'b00,
    FSC_BS_RUN  = 2'b01,
    FSC_BS_DONE = 2'b11
  } fsc_band_state_e;

endpackage : fsc_pkg

// *** src/fsc_top.sv ***
// Functional notes
// - bypass bit gives divide by one
// - ratio field codes 2..7 divide reference
// - two banks, second default with pin high
// - prescaler plus fraction averages N plus F
// - default pump code 31 gives 120uA
// - low current bit drops to 30uA
// - auto bandwidth uses gain calibration, off
// - active filter bit enables op-amp, else hi-z
// - keep-alive bit runs crystal while disabled
// - crystal coarse and fine load caps
// - mixer bias from four-bit word, default 100
// - enable rising edge starts band selection
// - dual bank bit lets pin pick bank
`timescale 1ns/1ns
module fsc_top #(
  parameter logic [10:0] BAND_SEL_LEN = fsc_pkg::BAND_SEL_PD_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [6:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  input  wire logic        chip_enable_i,
  input  wire logic        bank_mode_i,
  input  wire logic        vco_tick_i,
  input  wire logic [4:0]  vco_gain_code_i,
  output logic             pd_ref_pulse_o,
  output logic             fb_pulse_o,
  output logic             active_bank_o,
  output logic      [9:0]  int_divider_o,
  output logic      [23:0] frac_word_o,
  output logic      [4:0]  pump_current_setting_o,
  output logic      [7:0]  pump_scale_ua_o,
  output logic      [1:0]  band_select_factor_o,
  output logic             pd_polarity_o,
  output logic             opamp_en_o,
  output logic             filt_hiz_o,
  output logic             xtal_run_o,
  output logic             analog_en_o,
  output logic      [3:0]  xtal_cap_coarse_o,
  output logic             xtal_cap_fine_o,
  output logic      [3:0]  mixer_bias_code_o,
  output logic             band_sel_start_o,
  output logic             band_sel_busy_o
);

  // ===========================================================
  // Configuration registers
  logic [2:0]  ref_ratio_reg;
  logic        ref_divider_bypass_reg;
  logic        active_filter_en_reg;
  logic        pd_polarity_reg;
  logic        dual_bank_select_en_reg;
  logic [1:0]  band_select_factor_reg;
  logic        xtal_keep_alive_reg;
  logic        auto_bw_cal_reg;
  logic        pump_low_current_reg;
  logic [3:0]  mixer_bias_code_reg;
  logic [3:0]  xtal_cap_coarse_reg;
  logic        xtal_cap_fine_reg;
  logic [9:0]  int_reg [2];
  logic [15:0] frac_hi_reg [2];
  logic [7:0]  frac_lo_reg [2];
  logic [4:0]  pump_code_reg [2];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_ratio_reg          <= fsc_pkg::REF_RATIO_DEF;
      ref_divider_bypass_reg <= fsc_pkg::REF_BYPASS_DEF;
    end else if (reg_wr_i && reg_addr_i == fsc_pkg::ADDR_REF_DIV) begin
      ref_ratio_reg          <= reg_wdata_i[fsc_pkg::REF_RATIO_LSB +: 3];
      ref_divider_bypass_reg <= reg_wdata_i[fsc_pkg::REF_BYPASS_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_filter_en_reg    <= 1'b0;
      pd_polarity_reg         <= 1'b0;
      dual_bank_select_en_reg <= 1'b0;
      band_select_factor_reg  <= fsc_pkg::BAND_FACT_DEF;
      xtal_keep_alive_reg     <= 1'b0;
      auto_bw_cal_reg         <= 1'b0;
      pump_low_current_reg    <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == fsc_pkg::ADDR_CONFIG_WORD_ONE) begin
      active_filter_en_reg    <= reg_wdata_i[fsc_pkg::CONFIG_WORD_ONE_ACT_FILT];
      pd_polarity_reg         <= reg_wdata_i[fsc_pkg::CONFIG_WORD_ONE_PD_POL];
      dual_bank_select_en_reg <= reg_wdata_i[fsc_pkg::CONFIG_WORD_ONE_DUAL_BANK];
      band_select_factor_reg  <= reg_wdata_i[fsc_pkg::CONFIG_WORD_ONE_FACT_LSB +: 2];
      xtal_keep_alive_reg     <= reg_wdata_i[fsc_pkg::CONFIG_WORD_ONE_KEEP_XTAL];
      auto_bw_cal_reg         <= reg_wdata_i[fsc_pkg::CONFIG_WORD_ONE_AUTO_CAL];
      pump_low_current_reg    <= reg_wdata_i[fsc_pkg::CONFIG_WORD_ONE_PUMP_LOW];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mixer_bias_code_reg <= fsc_pkg::MIX_BIAS_DEF;
    end else if (reg_wr_i && reg_addr_i == fsc_pkg::ADDR_CONFIG_WORD_TWO) begin
      mixer_bias_code_reg <= reg_wdata_i[3:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xtal_cap_coarse_reg <= fsc_pkg::XTAL_COARSE_DEF;
      xtal_cap_fine_reg   <= fsc_pkg::XTAL_FINE_DEF;
    end else if (reg_wr_i && reg_addr_i == fsc_pkg::ADDR_CONFIG_WORD_FOUR) begin
      xtal_cap_coarse_reg <= reg_wdata_i[3:0];
      xtal_cap_fine_reg   <= reg_wdata_i[fsc_pkg::CONFIG_WORD_FOUR_FINE_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 2; i++) begin
        int_reg[i]       <= fsc_pkg::INT_DIV_DEF;
        frac_hi_reg[i]   <= 16'h0000;
        frac_lo_reg[i]   <= 8'h00;
        pump_code_reg[i] <= fsc_pkg::PUMP_CODE_DEF;
      end
    end else if (reg_wr_i) begin
      if (reg_addr_i == fsc_pkg::ADDR_A_INT) begin
        int_reg[0] <= reg_wdata_i[9:0];
      end else if (reg_addr_i == fsc_pkg::ADDR_B_INT) begin
        int_reg[1] <= reg_wdata_i[9:0];
      end else if (reg_addr_i == fsc_pkg::ADDR_A_FRAC_HI) begin
        frac_hi_reg[0] <= reg_wdata_i;
      end else if (reg_addr_i == fsc_pkg::ADDR_B_FRAC_HI) begin
        frac_hi_reg[1] <= reg_wdata_i;
      end else if (reg_addr_i == fsc_pkg::ADDR_A_FRAC_LO) begin
        frac_lo_reg[0] <= reg_wdata_i[7:0];
      end else if (reg_addr_i == fsc_pkg::ADDR_B_FRAC_LO) begin
        frac_lo_reg[1] <= reg_wdata_i[7:0];
      end else if (reg_addr_i == fsc_pkg::ADDR_A_PUMP) begin
        pump_code_reg[0] <= reg_wdata_i[4:0];
      end else if (reg_addr_i == fsc_pkg::ADDR_B_PUMP) begin
        pump_code_reg[1] <= reg_wdata_i[4:0];
      end
    end
  end

  // ===========================================================
  // Bank selection
  logic bank_reg;

  // pin picks bank in dual mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bank_reg <= fsc_pkg::BANK_B;
    end else if (dual_bank_select_en_reg) begin
      bank_reg <= bank_mode_i ? fsc_pkg::BANK_B : fsc_pkg::BANK_A;
    end else begin
      bank_reg <= fsc_pkg::BANK_B;
    end
  end

  // ===========================================================
  // Reference divider
  logic [2:0] ref_cnt_reg;
  logic [2:0] ref_eff;
  logic       ref_pulse_reg;

  // bypass forces ratio one
  // Codes 000 and 001 are treated as divide by one
  assign ref_eff = (ref_divider_bypass_reg || ref_ratio_reg < fsc_pkg::REF_RATIO_MIN)
                 ? fsc_pkg::REF_RATIO_ONE : ref_ratio_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_cnt_reg   <= 3'h0;
      ref_pulse_reg <= 1'b0;
    end else begin
      ref_pulse_reg <= ref_cnt_reg >= ref_eff - fsc_pkg::REF_RATIO_ONE;
      if (ref_cnt_reg >= ref_eff - fsc_pkg::REF_RATIO_ONE) begin
        ref_cnt_reg <= 3'h0;
      end else begin
        ref_cnt_reg <= ref_cnt_reg + 3'h1;
      end
    end
  end

  // ===========================================================
  // Feedback divider
  fsc_div_if div_bus ();

  assign div_bus.frac    = {frac_hi_reg[bank_reg], frac_lo_reg[bank_reg]};
  assign div_bus.int_div = int_reg[bank_reg];
  assign div_bus.tick    = vco_tick_i;

  fsc_frac_div u_frac_div (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d     (div_bus.div)
  );

  // ===========================================================
  // Analog control words
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pump_current_setting_o <= fsc_pkg::PUMP_CODE_DEF;
      pump_scale_ua_o        <= fsc_pkg::PUMP_FULL_UA;
    end else begin
      pump_current_setting_o <= auto_bw_cal_reg ? vco_gain_code_i : pump_code_reg[bank_reg];
      pump_scale_ua_o        <= pump_low_current_reg ? fsc_pkg::PUMP_LOW_UA
                                                     : fsc_pkg::PUMP_FULL_UA;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      opamp_en_o <= 1'b0;
      filt_hiz_o <= 1'b1;
      xtal_run_o <= 1'b0;
    end else begin
      opamp_en_o <= active_filter_en_reg;
      filt_hiz_o <= ~active_filter_en_reg;
      xtal_run_o <= chip_enable_i | xtal_keep_alive_reg;
    end
  end

  // ===========================================================
  // Band selection sequencer
  fsc_pkg::fsc_band_state_e bs_reg;
  logic        ce_prev_reg;
  logic        start_reg;
  logic [10:0] bs_cnt_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ce_prev_reg <= 1'b0;
      start_reg   <= 1'b0;
    end else begin
      ce_prev_reg <= chip_enable_i;
      start_reg   <= chip_enable_i & ~ce_prev_reg;
    end
  end

  // Counts detector clocks, so length tracks the programmed ratio
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bs_reg     <= fsc_pkg::FSC_BS_IDLE;
      bs_cnt_reg <= 11'h000;
    end else if (!chip_enable_i) begin
      bs_reg     <= fsc_pkg::FSC_BS_IDLE;
      bs_cnt_reg <= 11'h000;
    end else if (start_reg) begin
      bs_reg     <= fsc_pkg::FSC_BS_RUN;
      bs_cnt_reg <= 11'h000;
    end else begin
      case (bs_reg)
        fsc_pkg::FSC_BS_RUN: begin
          if (ref_pulse_reg) begin
            if (bs_cnt_reg == BAND_SEL_LEN - 11'h001) begin
              bs_reg <= fsc_pkg::FSC_BS_DONE;
            end
            bs_cnt_reg <= bs_cnt_reg + 11'h001;
          end
        end
        default: begin
          bs_reg <= bs_reg;
        end
      endcase
    end
  end

  // ===========================================================
  // Read port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      if (reg_addr_i == fsc_pkg::ADDR_REF_DIV) begin
        reg_rdata_o <= {ref_ratio_reg, ref_divider_bypass_reg, 12'h000};
      end else if (reg_addr_i == fsc_pkg::ADDR_CONFIG_WORD_ONE) begin
        reg_rdata_o <= {8'h00, pump_low_current_reg, auto_bw_cal_reg, xtal_keep_alive_reg,
                        band_select_factor_reg, dual_bank_select_en_reg, pd_polarity_reg,
                        active_filter_en_reg};
      end else if (reg_addr_i == fsc_pkg::ADDR_CONFIG_WORD_TWO) begin
        reg_rdata_o <= {12'h000, mixer_bias_code_reg};
      end else if (reg_addr_i == fsc_pkg::ADDR_CONFIG_WORD_FOUR) begin
        reg_rdata_o <= {11'h000, xtal_cap_fine_reg, xtal_cap_coarse_reg};
      end else if (reg_addr_i == fsc_pkg::ADDR_A_INT) begin
        reg_rdata_o <= {6'h00, int_reg[0]};
      end else if (reg_addr_i == fsc_pkg::ADDR_A_FRAC_HI) begin
        reg_rdata_o <= frac_hi_reg[0];
      end else if (reg_addr_i == fsc_pkg::ADDR_A_FRAC_LO) begin
        reg_rdata_o <= {8'h00, frac_lo_reg[0]};
      end else if (reg_addr_i == fsc_pkg::ADDR_A_PUMP) begin
        reg_rdata_o <= {11'h000, pump_code_reg[0]};
      end else if (reg_addr_i == fsc_pkg::ADDR_B_INT) begin
        reg_rdata_o <= {6'h00, int_reg[1]};
      end else if (reg_addr_i == fsc_pkg::ADDR_B_FRAC_HI) begin
        reg_rdata_o <= frac_hi_reg[1];
      end else if (reg_addr_i == fsc_pkg::ADDR_B_FRAC_LO) begin
        reg_rdata_o <= {8'h00, frac_lo_reg[1]};
      end else if (reg_addr_i == fsc_pkg::ADDR_B_PUMP) begin
        reg_rdata_o <= {11'h000, pump_code_reg[1]};
      end else if (reg_addr_i == fsc_pkg::ADDR_STATUS) begin
        reg_rdata_o <= {11'h000, div_bus.carry, xtal_run_o,
                        bs_reg == fsc_pkg::FSC_BS_DONE, band_sel_busy_o, bank_reg};
      end else begin
        reg_rdata_o <= 16'h0000;
      end
    end
  end

  // ===========================================================
  // Outputs
  assign pd_ref_pulse_o       = ref_pulse_reg;
  assign fb_pulse_o           = div_bus.fb_pulse;
  assign active_bank_o        = bank_reg;
  assign int_divider_o        = int_reg[bank_reg];
  assign frac_word_o          = div_bus.frac;
  assign band_select_factor_o = band_select_factor_reg;
  assign pd_polarity_o        = pd_polarity_reg;
  assign analog_en_o          = chip_enable_i;
  assign xtal_cap_coarse_o    = xtal_cap_coarse_reg;
  assign xtal_cap_fine_o      = xtal_cap_fine_reg;
  assign mixer_bias_code_o    = mixer_bias_code_reg;
  assign band_sel_start_o     = start_reg;
  assign band_sel_busy_o      = bs_reg == fsc_pkg::FSC_BS_RUN;

  // ===========================================================
  // Checks
  logic ref_wr;
  assign ref_wr = reg_wr_i && reg_addr_i == fsc_pkg::ADDR_REF_DIV;

  ref_bypass_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && $past(ref_divider_bypass_reg) |-> pd_ref_pulse_o)
    else $error("bypass does not give a pulse every cycle");

  ref_ratio_seven_a: assert property (@(posedge clk_i) disable iff (rst_i || ref_wr)
    (pd_ref_pulse_o && !ref_divider_bypass_reg && ref_ratio_reg == fsc_pkg::REF_RATIO_MAX)
    |=> (!pd_ref_pulse_o)[*6] ##1 pd_ref_pulse_o)
    else $error("reference ratio seven period wrong");

  bank_default_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !dual_bank_select_en_reg |=> active_bank_o == fsc_pkg::BANK_B)
    else $error("second bank not active by default");

  bank_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
    dual_bank_select_en_reg && !bank_mode_i && !reg_wr_i |=> active_bank_o == fsc_pkg::BANK_A)
    else $error("pin low did not select first bank");

  pump_default_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !pump_low_current_reg ##1 !pump_low_current_reg |-> pump_scale_ua_o == fsc_pkg::PUMP_FULL_UA)
    else $error("pump full scale not 120uA");

  pump_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pump_low_current_reg |=> pump_scale_ua_o == fsc_pkg::PUMP_LOW_UA)
    else $error("pump low current not 30uA");

  pump_manual_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !auto_bw_cal_reg |=> pump_current_setting_o == $past(pump_code_reg[bank_reg]))
    else $error("pump code not from programmed bank");

  opamp_hiz_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 (opamp_en_o != filt_hiz_o) && (opamp_en_o == $past(active_filter_en_reg)))
    else $error("op-amp enable and high impedance inconsistent");

  xtal_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !chip_enable_i && !xtal_keep_alive_reg |=> !xtal_run_o)
    else $error("crystal running while disabled without keep alive");

  band_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(chip_enable_i) ##1 chip_enable_i |-> band_sel_start_o ##1 band_sel_busy_o)
    else $error("enable edge did not start band selection");

  band_done_c: cover property (@(posedge clk_i) disable iff (rst_i)
    band_sel_busy_o ##1 bs_reg == fsc_pkg::FSC_BS_DONE);
  bank_switch_c: cover property (@(posedge clk_i) disable iff (rst_i)
    active_bank_o == fsc_pkg::BANK_B ##1 active_bank_o == fsc_pkg::BANK_A);
  auto_cal_c: cover property (@(posedge clk_i) disable iff (rst_i)
    auto_bw_cal_reg && pump_low_current_reg);

endmodule : fsc_top

// *** verification/fsc_vco_model.sv ***
`timescale 1ns/1ns
module fsc_vco_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] gap_i,
  output logic            vco_tick_o
);
  // ===========================================================
  // Prescaled VCO edges
  logic [2:0] cnt_reg;
  // Gap 0 ticks every cycle, 7 is the slowest VCO
  always_ff @(posedge clk_i) begin
    if (rst_i || cnt_reg >= gap_i) begin
      cnt_reg <= 3'h0;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    vco_tick_o <= !rst_i && (cnt_reg == gap_i);
  end
endmodule : fsc_vco_model

// *** verification/tb.sv ***
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; $display("ERROR %0t got %h exp %h", $time, a, e); end end
module tb;
  logic        clk_i = 0, rst_i = 1, reg_wr_i, reg_rd_i, chip_enable_i, bank_mode_i, vco_tick_i;
  logic [6:0]  reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o;
  logic [4:0]  vco_gain_code_i, pump_current_setting_o, p;
  logic [2:0]  gap;
  logic [1:0]  band_select_factor_o;
  logic [9:0]  int_divider_o;
  logic [23:0] frac_word_o;
  logic [7:0]  pump_scale_ua_o;
  logic [3:0]  xtal_cap_coarse_o, mixer_bias_code_o;
  logic        pd_ref_pulse_o, fb_pulse_o, active_bank_o, pd_polarity_o, opamp_en_o, filt_hiz_o;
  logic        xtal_run_o, analog_en_o, xtal_cap_fine_o, band_sel_start_o, band_sel_busy_o;
  logic [31:0] seed = 32'h1e, h;
  int          failures = 0, checked = 0, n, m;
  // Short band selection keeps the run brief
  fsc_top #(.BAND_SEL_LEN(11'h004)) DUT (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .chip_enable_i, .bank_mode_i, .vco_tick_i, .vco_gain_code_i,
    .pd_ref_pulse_o, .fb_pulse_o, .active_bank_o, .int_divider_o, .frac_word_o,
    .pump_current_setting_o, .pump_scale_ua_o, .band_select_factor_o, .pd_polarity_o,
    .opamp_en_o, .filt_hiz_o, .xtal_run_o, .analog_en_o, .xtal_cap_coarse_o, .xtal_cap_fine_o,
    .mixer_bias_code_o, .band_sel_start_o, .band_sel_busy_o);
  fsc_vco_model vco (.clk_i, .rst_i, .gap_i(gap), .vco_tick_o(vco_tick_i));
  always #4 clk_i = ~clk_i;
  // ===========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [23:0] frac_exp(logic [15:0] hi, logic [15:0] lo);
    return {hi, lo[7:0]};
  endfunction : frac_exp
  task automatic tk(int k = 1);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : tk
  task automatic wr(logic [6:0] a, logic [15:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(logic [6:0] a, logic [15:0] e);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK(reg_rdata_o, e)
  endtask : rd
  // Cycles (fb 0) or VCO ticks (fb 1) from one pulse to the next
  task automatic meas(bit fb, output int c);
    int i;
    i = 0;
    c = 0;
    while ((fb ? fb_pulse_o : pd_ref_pulse_o) !== 1'b1 && i < 3000) begin
      tk();
      i++;
    end
    do begin
      c += fb ? int'(vco_tick_i) : 1;
      tk();
      i++;
    end while ((fb ? fb_pulse_o : pd_ref_pulse_o) !== 1'b1 && i < 3000);
  endtask : meas
  task automatic stop_test();
    if (failures == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  initial begin
    #(30000 * 8);
    failures++;
    stop_test();
  end
  // ===========================================================
  // Main sequence
  initial begin
    {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, chip_enable_i, bank_mode_i} = '0;
    h = rnd();
    vco_gain_code_i = h[4:0];
    gap = h[7:5];
    tk(6);
    rst_i <= 1'b0;
    tk();
    `CHK({active_bank_o, pump_current_setting_o, pump_scale_ua_o}, 14'h3f78)
    `CHK({xtal_cap_coarse_o, xtal_cap_fine_o, mixer_bias_code_o}, 9'h084)
    `CHK({band_select_factor_o, opamp_en_o, filt_hiz_o}, 4'h5)
    rd(7'h00, 16'h5000);
    rd(7'h01, 16'h0008);
    rd(7'h7f, 16'h0000);
    for (int r = 2; r < 9; r++) begin
      wr(7'h00, r == 8 ? 16'hf000 : 16'(r) << 13);
      meas(0, n);
      meas(0, n);
      `CHK(n, r == 8 ? 1 : r)
    end
    h = rnd();
    wr(7'h01, 16'h0000);
    wr(7'h08, 16'd15);
    wr(7'h09, h[31:16]);
    wr(7'h0a, h[15:0]);
    tk(2);
    `CHK(int_divider_o, 10'd15)
    `CHK(frac_word_o, frac_exp(h[31:16], h[15:0]))
    wr(7'h09, 16'h8000);
    wr(7'h0a, 16'h0000);
    meas(1, n);
    meas(1, n);
    meas(1, m);
    `CHK(n + m, 31)
    wr(7'h09, 16'h0000);
    meas(1, n);
    meas(1, n);
    `CHK(n, 15)
    n = 15 + int'(h[8:0]) % 497;
    wr(7'h04, 16'(n));
    wr(7'h01, 16'h0004);
    tk(3);
    `CHK({active_bank_o, int_divider_o, band_select_factor_o}, {1'b0, 10'(n), 2'h0})
    bank_mode_i <= 1'b1;
    p = h[13:9];
    wr(7'h0b, 16'(p));
    tk(3);
    `CHK({active_bank_o, int_divider_o, pump_current_setting_o}, {1'b1, 10'd15, p})
    wr(7'h01, 16'h0080);
    tk(3);
    `CHK(pump_scale_ua_o, 8'h1e)
    wr(7'h01, 16'h00c0);
    tk(3);
    `CHK({pump_current_setting_o, pump_scale_ua_o}, {vco_gain_code_i, 8'h1e})
    wr(7'h01, 16'h0003);
    tk(3);
    `CHK({opamp_en_o, filt_hiz_o, pd_polarity_o}, 3'b101)
    wr(7'h01, 16'h0020);
    tk(3);
    `CHK({xtal_run_o, opamp_en_o, filt_hiz_o}, 3'b101)
    wr(7'h01, 16'h0000);
    wr(7'h02, h[30:15]);
    wr(7'h03, h[31:16]);
    tk(3);
    `CHK(xtal_run_o, 1'b0)
    `CHK({xtal_cap_coarse_o, xtal_cap_fine_o}, {h[19:16], h[20]})
    `CHK(mixer_bias_code_o, h[18:15])
    rd(7'h04, 16'(n));
    @(posedge clk_i);
    chip_enable_i <= 1'b1;
    tk();
    `CHK({band_sel_start_o, analog_en_o}, 2'b11)
    tk();
    `CHK({band_sel_busy_o, xtal_run_o}, 2'b11)
    n = 0;
    while (band_sel_busy_o !== 1'b0 && n < 60) begin
      tk();
      n++;
    end
    `CHK(band_sel_busy_o, 1'b0)
    rd(7'h0c, 16'h000d);
    stop_test();
  end
endmodule : tb
